// >>> tsf_pkg.sv
// Shared constants and encodings for the transmit sum tree and output formatter
`default_nettype none
package tsf_pkg;
	// ----------------------------------------
	// Widths and counts
	// ----------------------------------------
	localparam int MIX_W = 21;
	localparam int COMB_W = 23;
	localparam int NODE_W = 22;
	localparam int SUM_W = 25;
	localparam int WIDE_W = 32;
	localparam int PORT_W = 16;
	localparam int LOW_W = 6;
	localparam int SEL_W = 8;
	localparam int N_CH = 4;
	localparam int N_PATHS = 6;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CAS_LAT = 14;
	localparam int FIXED_STAGES = 6;
	localparam int CAS_DLY = CAS_LAT - FIXED_STAGES;
	// ----------------------------------------
	// Arithmetic positions
	// ----------------------------------------
	localparam int COMB_DOWN = 4;
	localparam int NARROW_POS = NODE_W - PORT_W;
	localparam int CD_UPSHIFT = 1;
	// ----------------------------------------
	// Path indices
	// ----------------------------------------
	localparam int PATH_IA = 0;
	localparam int PATH_QA = 1;
	localparam int PATH_IB = 2;
	localparam int PATH_QB = 3;
	localparam int PATH_IC = 4;
	localparam int PATH_ID = 5;
	// ----------------------------------------
	// Control encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		CAS_OFF = 2'h0,
		CAS_HALF_CPLX = 2'h1,
		CAS_NARROW = 2'h2,
		CAS_FULL = 2'h3
	} tsf_cas_fmt_t;
	localparam logic [1:0] RND_22 = 2'h0;
	localparam logic [1:0] RND_16 = 2'h1;
	localparam logic [1:0] RND_14 = 2'h2;
	localparam logic [1:0] RND_12 = 2'h3;
	localparam logic [3:0] P2_ZERO = 4'h0;
	localparam logic [3:0] P2_IB = 4'h1;
	localparam logic [3:0] P2_QA = 4'h2;
	localparam logic [3:0] P2_LOW = 4'h4;
	localparam logic [3:0] P2_INV = 4'h8;
	localparam logic [2:0] P3_ZERO = 3'h0;
	localparam logic [2:0] P3_IC = 3'h1;
	localparam logic [2:0] P3_IB = 3'h2;
	localparam logic [2:0] P3_QA = 3'h4;
	localparam logic [4:0] P4_ZERO = 5'h00;
	localparam logic [4:0] P4_ID = 5'h01;
	localparam logic [4:0] P4_QB = 5'h02;
	localparam logic [4:0] P4_IB_LOW = 5'h04;
	localparam logic [4:0] P4_QA_LOW = 5'h08;
	localparam logic [4:0] P4_INV = 5'h10;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [NODE_W-1:0] NODE_RST = 22'h000000;
	localparam logic [PORT_W-1:0] PORT_RST = 16'h0000;
endpackage : tsf_pkg
`default_nettype wire

// >>> tsf_fmt_if.sv
// Carrier between the formatter top and one round and limit stage
`timescale 1ns/1ps
`default_nettype none
interface tsf_fmt_if;
	import tsf_pkg::*;
	logic [NODE_W-1:0] word_in;
	logic [1:0] round_code;
	logic narrow;
	logic force_ovf;
	logic [NODE_W-1:0] word_out;
	modport top (output word_in, output round_code, output narrow, output force_ovf,
		input word_out);
	modport stage (input word_in, input round_code, input narrow, input force_ovf,
		output word_out);
endinterface : tsf_fmt_if
`default_nettype wire

// >>> tsf_round_limit.sv
// Round to a chosen width, clear the low bits and hard limit; one register stage
`timescale 1ns/1ps
`default_nettype none
module tsf_round_limit (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Word to format
	tsf_fmt_if.stage fmt
);
	import tsf_pkg::*;

	typedef struct packed {
		logic [NODE_W-1:0] word;
	} tsf_rl_st_t;

	tsf_rl_st_t st_ff;
	tsf_rl_st_t nxt_st;

	// ----------------------------------------
	// Round, then limit
	// ----------------------------------------
	always_comb begin
		logic [4:0] drop;
		logic [NODE_W:0] sum;
		logic [NODE_W-1:0] mask;
		logic ovf;
		drop = 5'h00;
		nxt_st = st_ff;
		case (fmt.round_code)
			RND_22: drop = fmt.narrow ? 5'(NARROW_POS) : 5'h00;
			RND_16: drop = 5'(NODE_W - 16);
			RND_14: drop = 5'(NODE_W - 14);
			RND_12: drop = 5'(NODE_W - 12);
			default: drop = 5'h00;
		endcase
		mask = {NODE_W{1'b1}} << drop;
		sum = {fmt.word_in[NODE_W-1], fmt.word_in};
		if (drop != 5'h00) begin
			sum = sum + ((NODE_W + 1)'(1) << (drop - 5'h01));
		end
		// A carry into the sign marks overflow; quiet mode fakes one to pin the bus at positive full scale
		ovf = (sum[NODE_W] != sum[NODE_W-1]) || fmt.force_ovf;
		if (ovf) begin
			nxt_st.word = (sum[NODE_W] && !fmt.force_ovf) ?
				{1'b1, {(NODE_W - 1){1'b0}}} : ({1'b0, {(NODE_W - 1){1'b1}}} & mask);
		end else begin
			nxt_st.word = sum[NODE_W-1:0] & mask;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fmt.word_out = st_ff.word;
endmodule : tsf_round_limit
`default_nettype wire

// >>> tsf_formatter.sv
// Transmit sum tree, cascade sum input, scaling, rounding and output port steering
// Summary of operation
// - Mixer words are 21 bits; combiner adds up to four into 23 bits.
// - Wide cascade: combiner shifted down four, rounded to 19, added into 22-bit input.
// - Cascade off or 16-bit form: combiner added without the four-bit down-shift.
// - Final sum upshifted 0 to 7, overflow checked, rounded, then hard limited.
// - Overflow saturates to full scale; rounding clears bits below the width.
// - Cascade port to first and second output ports takes exactly 14 clocks.
// - Eight-bit selects per I and Q steer four mixers into two sums.
// - Cascade enabled turns ports three and four into inputs; format zero adds nothing.
// - Format 1: half-rate complex 22-bit input split across ports three and four.
// - Cascade sync marks the I word; flag also marks output I words 14 later.
// - Format 2: port three into first I node, port four into second I, first Q.
// - Format 3: full-rate 22-bit path; other three summers off.
// - Third and fourth paths lack the upshifter; shift 1 matches their gain.
// - First and second paths may interleave I and Q, phased by cascade sync.
// - First pair round codes 3,2,1,0 give 12,14,16,22 bits, low bits zeroed.
// - Third and fourth paths: delayed, upshifted one bit, limited to 16 bits.
// - Quiet control forces overflow on third and fourth paths, pinning them at positive full scale.
// - Offset binary inverts output msb; port one carries first I path, or first Q on Q words when interleaved.
// - Port two: zero, second I, first Q, low bits, or port one complement.
// - Port three: zero, third path, second I, or first Q by code.
`timescale 1ns/1ps
`default_nettype none
module tsf_formatter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Mixer outputs, channels a to d
	input wire logic [tsf_pkg::N_CH-1:0][tsf_pkg::MIX_W-1:0] mix_inphase,
	input wire logic [tsf_pkg::N_CH-1:0][tsf_pkg::MIX_W-1:0] mix_quadrature,
	// Cascade pins
	input wire logic [tsf_pkg::PORT_W-1:0] port_three_in,
	input wire logic [tsf_pkg::PORT_W-1:0] port_four_in,
	input wire logic cascade_sync,
	// Configuration
	input wire logic [tsf_pkg::SEL_W-1:0] inphase_combine_select,
	input wire logic [tsf_pkg::SEL_W-1:0] quadrature_combine_select,
	input wire logic [1:0] cascade_format,
	input wire logic [2:0] sum_shift,
	input wire logic [1:0] first_pair_round_width,
	input wire logic first_pair_iq_interleave,
	input wire logic [1:0] second_pair_round_width,
	input wire logic second_pair_iq_interleave,
	input wire logic second_pair_quiet,
	input wire logic offset_binary,
	input wire logic [3:0] port_two_source,
	input wire logic [2:0] port_three_source,
	input wire logic [4:0] port_four_source,
	// Output ports
	output logic [tsf_pkg::PORT_W-1:0] output_port_one,
	output logic [tsf_pkg::PORT_W-1:0] output_port_two,
	output logic [tsf_pkg::PORT_W-1:0] output_port_three,
	output logic output_port_three_oe,
	output logic [tsf_pkg::PORT_W-1:0] output_port_four,
	output logic output_port_four_oe,
	output logic inphase_flag
);
	import tsf_pkg::*;

	typedef struct packed {
		logic [PORT_W-1:0] p3_s1;
		logic [PORT_W-1:0] p3_s2;
		logic [PORT_W-1:0] p4_s1;
		logic [PORT_W-1:0] p4_s2;
		logic sync_s1;
		logic sync_s2;
		logic phase;
		logic [CAS_DLY-1:0][2*PORT_W:0] dly;
		logic [N_PATHS-1:0][SUM_W-1:0] node;
		logic node_ph;
		logic [N_PATHS-1:0][NODE_W-1:0] scaled;
		logic scaled_ph;
		logic rnd_ph;
		logic [PORT_W-1:0] p1;
		logic [PORT_W-1:0] p2;
		logic [PORT_W-1:0] p3;
		logic [PORT_W-1:0] p4;
		logic out_ph;
	} tsf_main_st_t;

	tsf_main_st_t st_ff;
	tsf_main_st_t nxt_st;
	logic [N_PATHS-1:0][NODE_W-1:0] rnd;

	// ----------------------------------------
	// Arithmetic helpers
	// ----------------------------------------
	function automatic logic signed [COMB_W-1:0] comb_b(input logic [SEL_W-1:0] s,
		input logic [N_CH-1:0][MIX_W-1:0] m);
		logic signed [COMB_W-1:0] r;
		r = '0;
		if (s[5]) r = r + COMB_W'(signed'(m[3]));
		if (s[6]) r = r + COMB_W'(signed'(m[1]));
		if (s[7]) r = r + COMB_W'(signed'(m[2]));
		return r;
	endfunction : comb_b

	function automatic logic signed [COMB_W-1:0] comb_a(input logic [SEL_W-1:0] s,
		input logic [N_CH-1:0][MIX_W-1:0] m);
		logic signed [COMB_W-1:0] inner;
		logic signed [COMB_W-1:0] r;
		inner = '0;
		r = '0;
		if (s[1]) inner = inner + COMB_W'(signed'(m[0]));
		if (s[2]) inner = inner + COMB_W'(signed'(m[1]));
		if (s[3]) inner = inner + COMB_W'(signed'(m[2]));
		if (s[0]) r = inner;
		if (s[4]) r = r + comb_b(s, m);
		return r;
	endfunction : comb_a

	// Wide cascade leaves headroom for eight chips, so the tree drops four bits
	function automatic logic signed [SUM_W-1:0] comb_node(input logic signed [COMB_W-1:0] c,
		input logic wide);
		logic signed [SUM_W-1:0] e;
		e = SUM_W'(c);
		if (wide) begin
			e = (e + SUM_W'(1 << (COMB_DOWN - 1))) >>> COMB_DOWN;
		end
		return e;
	endfunction : comb_node

	function automatic logic [NODE_W-1:0] sat_node(input logic signed [WIDE_W-1:0] v);
		if (v > WIDE_W'(signed'({1'b0, {(NODE_W - 1){1'b1}}}))) begin
			return {1'b0, {(NODE_W - 1){1'b1}}};
		end else if (v < WIDE_W'(signed'({1'b1, {(NODE_W - 1){1'b0}}}))) begin
			return {1'b1, {(NODE_W - 1){1'b0}}};
		end
		return v[NODE_W-1:0];
	endfunction : sat_node

	function automatic logic [PORT_W-1:0] msb_fmt(input logic [PORT_W-1:0] w, input logic ob);
		return {w[PORT_W-1] ^ ob, w[PORT_W-2:0]};
	endfunction : msb_fmt

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [PORT_W-1:0] w3;
		logic [PORT_W-1:0] w4;
		logic ph;
		logic wide;
		logic signed [SUM_W-1:0] cas22;
		logic signed [SUM_W-1:0] cas3n;
		logic signed [SUM_W-1:0] cas4n;
		logic [MIX_W-1:0] cd_c;
		logic [MIX_W-1:0] cd_d;
		logic [NODE_W-1:0] pa;
		logic [NODE_W-1:0] pb;
		logic [PORT_W-1:0] p1;
		logic [PORT_W-1:0] p3;
		// Every local starts from a known value so no path can infer a latch
		w3 = PORT_RST;
		w4 = PORT_RST;
		ph = 1'b0;
		wide = 1'b0;
		cas22 = '0;
		cas3n = '0;
		cas4n = '0;
		cd_c = '0;
		cd_d = '0;
		pa = NODE_RST;
		pb = NODE_RST;
		p1 = PORT_RST;
		p3 = PORT_RST;
		nxt_st = st_ff;
		// Pins pass two flops before any logic looks at them
		nxt_st.p3_s1 = port_three_in;
		nxt_st.p3_s2 = st_ff.p3_s1;
		nxt_st.p4_s1 = port_four_in;
		nxt_st.p4_s2 = st_ff.p4_s1;
		nxt_st.sync_s1 = cascade_sync;
		nxt_st.sync_s2 = st_ff.sync_s1;
		// Sync marks the I word; the phase then alternates
		nxt_st.phase = st_ff.sync_s2 ? 1'b1 : ~st_ff.phase;
		// Pad the cascade path so pin to output is fixed
		nxt_st.dly = {st_ff.dly[CAS_DLY-2:0], {nxt_st.phase, st_ff.p4_s2, st_ff.p3_s2}};
		w3 = st_ff.dly[CAS_DLY-1][PORT_W-1:0];
		w4 = st_ff.dly[CAS_DLY-1][2*PORT_W-1:PORT_W];
		ph = st_ff.dly[CAS_DLY-1][2*PORT_W];

		// ---- Sum stage ----
		wide = (cascade_format == CAS_HALF_CPLX) || (cascade_format == CAS_FULL);
		cas22 = SUM_W'(signed'({w3, w4[PORT_W-1:PORT_W-LOW_W]}));
		cas3n = SUM_W'(signed'({w3, {NARROW_POS{1'b0}}}));
		cas4n = SUM_W'(signed'({w4, {NARROW_POS{1'b0}}}));
		nxt_st.node[PATH_IA] = comb_node(comb_a(inphase_combine_select, mix_inphase), wide);
		nxt_st.node[PATH_IB] = comb_node(comb_b(inphase_combine_select, mix_inphase), wide);
		nxt_st.node[PATH_QA] = comb_node(comb_a(quadrature_combine_select, mix_quadrature), wide);
		nxt_st.node[PATH_QB] = comb_node(comb_b(quadrature_combine_select, mix_quadrature), wide);
		case (cascade_format)
			CAS_HALF_CPLX: begin
				if (ph) nxt_st.node[PATH_IA] = nxt_st.node[PATH_IA] + cas22;
				else nxt_st.node[PATH_QA] = nxt_st.node[PATH_QA] + cas22;
				nxt_st.node[PATH_IB] = '0;
				nxt_st.node[PATH_QB] = '0;
			end
			CAS_NARROW: begin
				nxt_st.node[PATH_IA] = nxt_st.node[PATH_IA] + cas3n;
				nxt_st.node[PATH_IB] = nxt_st.node[PATH_IB] + cas4n;
				nxt_st.node[PATH_QA] = nxt_st.node[PATH_QA] + cas4n;
			end
			CAS_FULL: begin
				nxt_st.node[PATH_IA] = nxt_st.node[PATH_IA] + cas22;
				nxt_st.node[PATH_IB] = '0;
				nxt_st.node[PATH_QA] = '0;
				nxt_st.node[PATH_QB] = '0;
			end
			default: ;
		endcase

		// Separate third and fourth paths get a fixed one-bit upshift
		cd_c = (second_pair_iq_interleave && !ph) ? mix_quadrature[2] : mix_inphase[2];
		cd_d = (second_pair_iq_interleave && !ph) ? mix_quadrature[3] : mix_inphase[3];
		nxt_st.node[PATH_IC] = SUM_W'(signed'({cd_c, {CD_UPSHIFT{1'b0}}}));
		nxt_st.node[PATH_ID] = SUM_W'(signed'({cd_d, {CD_UPSHIFT{1'b0}}}));
		nxt_st.node_ph = ph;

		// ---- Scale stage ----
		for (int k = 0; k < PATH_IC; k++) begin
			nxt_st.scaled[k] = sat_node(WIDE_W'(signed'(st_ff.node[k])) <<< sum_shift);
		end
		// No shifter on the third and fourth paths
		nxt_st.scaled[PATH_IC] = st_ff.node[PATH_IC][NODE_W-1:0];
		nxt_st.scaled[PATH_ID] = st_ff.node[PATH_ID][NODE_W-1:0];
		nxt_st.scaled_ph = st_ff.node_ph;
		nxt_st.rnd_ph = st_ff.scaled_ph;

		// ---- Output stage ----
		pa = (first_pair_iq_interleave && !st_ff.rnd_ph) ? rnd[PATH_QA] : rnd[PATH_IA];
		pb = (first_pair_iq_interleave && !st_ff.rnd_ph) ? rnd[PATH_QB] : rnd[PATH_IB];
		p1 = msb_fmt(pa[NODE_W-1:NARROW_POS], offset_binary);
		nxt_st.p1 = p1;
		// Low-bit words skip the offset-binary flip; they carry no sign
		case (port_two_source)
			P2_ZERO: nxt_st.p2 = PORT_RST;
			P2_IB: nxt_st.p2 = msb_fmt(pb[NODE_W-1:NARROW_POS], offset_binary);
			P2_QA: nxt_st.p2 = msb_fmt(rnd[PATH_QA][NODE_W-1:NARROW_POS], offset_binary);
			P2_LOW: nxt_st.p2 = {pa[LOW_W-1:0], {(PORT_W - LOW_W){1'b0}}};
			P2_INV: nxt_st.p2 = ~p1;
			default: nxt_st.p2 = PORT_RST;
		endcase
		case (port_three_source)
			P3_ZERO: p3 = PORT_RST;
			P3_IC: p3 = msb_fmt(rnd[PATH_IC][NODE_W-1:NARROW_POS], offset_binary);
			P3_IB: p3 = msb_fmt(pb[NODE_W-1:NARROW_POS], offset_binary);
			P3_QA: p3 = msb_fmt(rnd[PATH_QA][NODE_W-1:NARROW_POS], offset_binary);
			default: p3 = PORT_RST;
		endcase
		nxt_st.p3 = p3;
		case (port_four_source)
			P4_ZERO: nxt_st.p4 = PORT_RST;
			P4_ID: nxt_st.p4 = msb_fmt(rnd[PATH_ID][NODE_W-1:NARROW_POS], offset_binary);
			P4_QB: nxt_st.p4 = msb_fmt(rnd[PATH_QB][NODE_W-1:NARROW_POS], offset_binary);
			P4_IB_LOW: nxt_st.p4 = {rnd[PATH_IB][LOW_W-1:0], {(PORT_W - LOW_W){1'b0}}};
			P4_QA_LOW: nxt_st.p4 = {rnd[PATH_QA][LOW_W-1:0], {(PORT_W - LOW_W){1'b0}}};
			P4_INV: nxt_st.p4 = ~p3;
			default: nxt_st.p4 = PORT_RST;
		endcase
		nxt_st.out_ph = st_ff.rnd_ph;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Round and limit stages, one per path
	// ----------------------------------------
	tsf_fmt_if fmt [N_PATHS] ();

	for (genvar g = 0; g < N_PATHS; g++) begin : g_path
		assign fmt[g].word_in = st_ff.scaled[g];
		assign fmt[g].round_code = (g >= PATH_IC) ? second_pair_round_width : first_pair_round_width;
		// The second pair never rounds wider than its 16-bit port
		assign fmt[g].narrow = (g >= PATH_IC);
		assign fmt[g].force_ovf = (g >= PATH_IC) && second_pair_quiet;
		assign rnd[g] = fmt[g].word_out;
		tsf_round_limit u_round (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.fmt(fmt[g])
		);
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign output_port_one = st_ff.p1;
	assign output_port_two = st_ff.p2;
	assign output_port_three = st_ff.p3;
	assign output_port_four = st_ff.p4;
	// Cascade input enabled turns the pair around
	assign output_port_three_oe = (cascade_format == CAS_OFF);
	assign output_port_four_oe = (cascade_format == CAS_OFF);
	assign inphase_flag = st_ff.out_ph;
endmodule : tsf_formatter
`default_nettype wire

// >>> tsf_formatter_assertions.sv
// Port checker for the transmit sum tree and output formatter
`timescale 1ns/1ps
`default_nettype none
module tsf_formatter_checker (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Watched inputs
	input wire logic [tsf_pkg::N_CH-1:0][tsf_pkg::MIX_W-1:0] mix_inphase,
	input wire logic [tsf_pkg::N_CH-1:0][tsf_pkg::MIX_W-1:0] mix_quadrature,
	input wire logic [tsf_pkg::PORT_W-1:0] port_three_in,
	input wire logic [tsf_pkg::PORT_W-1:0] port_four_in,
	input wire logic cascade_sync,
	input wire logic [1:0] cascade_format,
	input wire logic [2:0] sum_shift,
	input wire logic [1:0] first_pair_round_width,
	input wire logic first_pair_iq_interleave,
	input wire logic offset_binary,
	input wire logic [3:0] port_two_source,
	input wire logic [2:0] port_three_source,
	input wire logic [4:0] port_four_source,
	// Watched outputs
	input wire logic [tsf_pkg::PORT_W-1:0] output_port_one,
	input wire logic [tsf_pkg::PORT_W-1:0] output_port_two,
	input wire logic [tsf_pkg::PORT_W-1:0] output_port_three,
	input wire logic output_port_three_oe,
	input wire logic [tsf_pkg::PORT_W-1:0] output_port_four,
	input wire logic output_port_four_oe,
	input wire logic inphase_flag
);
	import tsf_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [4:0] run_ff;
	logic [4:0] clean_ff;
	logic clean;
	// Pass-through setting: cascade word reaches port one untouched
	assign clean = cascade_format == CAS_FULL && sum_shift == 3'h0 && !offset_binary
		&& first_pair_round_width == RND_22 && !first_pair_iq_interleave
		&& port_two_source == P2_LOW && mix_inphase == '0 && mix_quadrature == '0;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			run_ff <= 5'h00;
			clean_ff <= 5'h00;
		end else begin
			run_ff <= (run_ff == 5'h1F) ? run_ff : run_ff + 5'h01;
			clean_ff <= !clean ? 5'h00 : (clean_ff == 5'h1F) ? clean_ff : clean_ff + 5'h01;
		end
	end
	property p_oe_three;
		output_port_three_oe == (cascade_format == CAS_OFF);
	endproperty
	a_oe_three: assert property (p_oe_three) else $error("port three enable wrong");
	property p_oe_four;
		output_port_four_oe == (cascade_format == CAS_OFF);
	endproperty
	a_oe_four: assert property (p_oe_four) else $error("port four enable wrong");
	property p_cas_latency;
		clean_ff >= 5'h10 |-> output_port_one == $past(port_three_in, 14);
	endproperty
	a_cas_latency: assert property (p_cas_latency) else $error("cascade latency wrong");
	property p_cas_low;
		clean_ff >= 5'h10 |-> output_port_two == {$past(port_four_in[15:10], 14), 10'h000};
	endproperty
	a_cas_low: assert property (p_cas_low) else $error("low bits wrong");
	property p_two_inv;
		$past(rst_n) && $past(port_two_source) == P2_INV |-> output_port_two == ~output_port_one;
	endproperty
	a_two_inv: assert property (p_two_inv) else $error("port two complement wrong");
	property p_two_zero;
		$past(rst_n) && $past(port_two_source) == P2_ZERO |-> output_port_two == 16'h0000;
	endproperty
	a_two_zero: assert property (p_two_zero) else $error("port two not zero");
	property p_three_zero;
		$past(rst_n) && $past(port_three_source) == P3_ZERO |-> output_port_three == 16'h0000;
	endproperty
	a_three_zero: assert property (p_three_zero) else $error("port three not zero");
	property p_four_inv;
		$past(rst_n) && $past(port_four_source) == P4_INV |-> output_port_four == ~output_port_three;
	endproperty
	a_four_inv: assert property (p_four_inv) else $error("port four complement wrong");
	property p_four_zero;
		$past(rst_n) && $past(port_four_source) == P4_ZERO |-> output_port_four == 16'h0000;
	endproperty
	a_four_zero: assert property (p_four_zero) else $error("port four not zero");
	property p_flag_sync;
		run_ff >= 5'h10 && $past(cascade_sync, 14) |-> inphase_flag;
	endproperty
	a_flag_sync: assert property (p_flag_sync) else $error("flag missed sync");
	property p_flag_alt;
		run_ff >= 5'h10 && !$past(cascade_sync, 14) |-> inphase_flag != $past(inphase_flag);
	endproperty
	a_flag_alt: assert property (p_flag_alt) else $error("flag did not alternate");
	c_clean: cover property (clean_ff == 5'h1F);
	c_sync: cover property (run_ff >= 5'h10 && $past(cascade_sync, 14) && inphase_flag);
	c_inv: cover property ($past(port_four_source) == P4_INV);
endmodule : tsf_formatter_checker
bind tsf_formatter tsf_formatter_checker i_tsf_formatter_checker (
	.clk_sys(clk_sys), .rst_n(rst_n), .mix_inphase(mix_inphase),
	.mix_quadrature(mix_quadrature), .port_three_in(port_three_in),
	.port_four_in(port_four_in), .cascade_sync(cascade_sync), .cascade_format(cascade_format),
	.sum_shift(sum_shift), .first_pair_round_width(first_pair_round_width),
	.first_pair_iq_interleave(first_pair_iq_interleave), .offset_binary(offset_binary),
	.port_two_source(port_two_source), .port_three_source(port_three_source),
	.port_four_source(port_four_source), .output_port_one(output_port_one),
	.output_port_two(output_port_two), .output_port_three(output_port_three),
	.output_port_three_oe(output_port_three_oe), .output_port_four(output_port_four),
	.output_port_four_oe(output_port_four_oe), .inphase_flag(inphase_flag)
);
`default_nettype wire

// >>> tsf_cascade_source.sv
// Upstream cascade chip driving the sum input pins
`timescale 1ns/1ps
`default_nettype none
module tsf_cascade_source (
	// Clock
	input wire logic clk_sys,
	// Word to send and its phase
	input wire logic [21:0] word,
	input wire logic word_is_i,
	// Sum input pins
	output logic [15:0] port_three_in,
	output logic [15:0] port_four_in,
	output logic cascade_sync
);
	logic [9:0] noise = 10'h2A5;
	// Unused pins flip each cycle so a stale value never looks like data
	always @(negedge clk_sys) noise <= ~noise;
	// Upstream chip rounds to the full 22-bit chain width and leaves the upshift to us
	assign port_three_in = word[21:6];
	assign port_four_in = {word[5:0], noise};
	assign cascade_sync = word_is_i;
endmodule : tsf_cascade_source
`default_nettype wire

// >>> tsf_formatter_test.sv
// Self-checking bench for the transmit formatter
`timescale 1ns/1ps
`default_nettype none
module tsf_formatter_test;
	import tsf_pkg::*;
	logic clk_sys, rst_n, sync, cas_i, ilv, ilv2, quiet, off, oe3, oe4, flag;
	logic [N_CH-1:0][MIX_W-1:0] mix_i, mix_q;
	logic [15:0] p3_in, p4_in, o1, o2, o3, o4, e1, e2;
	logic [21:0] cas_word;
	logic [7:0] sel_i, sel_q;
	logic [1:0] fmt, rnd, rnd2;
	logic [2:0] shift, src3;
	logic [3:0] src2;
	logic [4:0] src4;
	logic [31:0] xv;
	int errors, comparisons, v, ma[4], mq[4], wq[$];
	bit iq[$];
	logic [3:0] codes2 [3] = '{P2_ZERO, P2_LOW, P2_INV};
	logic [7:0] sels [4] = '{8'h00, 8'h43, 8'hA7, 8'hB7};
	tsf_cascade_source i_tsf_cascade_source (.clk_sys(clk_sys), .word(cas_word),
		.word_is_i(cas_i), .port_three_in(p3_in), .port_four_in(p4_in), .cascade_sync(sync));
	tsf_formatter i_tsf_formatter (
		.clk_sys(clk_sys), .rst_n(rst_n), .mix_inphase(mix_i), .mix_quadrature(mix_q),
		.port_three_in(p3_in), .port_four_in(p4_in), .cascade_sync(sync),
		.inphase_combine_select(sel_i), .quadrature_combine_select(sel_q),
		.cascade_format(fmt), .sum_shift(shift), .first_pair_round_width(rnd),
		.first_pair_iq_interleave(ilv), .second_pair_round_width(rnd2),
		.second_pair_iq_interleave(ilv2), .second_pair_quiet(quiet), .offset_binary(off),
		.port_two_source(src2), .port_three_source(src3), .port_four_source(src4),
		.output_port_one(o1), .output_port_two(o2), .output_port_three(o3),
		.output_port_three_oe(oe3), .output_port_four(o4), .output_port_four_oe(oe4),
		.inphase_flag(flag));
	task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// Shift, saturate to 22 bits, round to the chosen width, limit again
	function automatic int fmodel(int x, int sh, int code);
		int m;
		x = x <<< sh;
		// Signed bounds keep the compares signed
		if (x > 32'sh1FFFFF) x = 32'sh1FFFFF;
		if (x < -32'sh200000) x = -32'sh200000;
		m = (code == 0) ? 1 : 1 << (4 + 2 * code);
		x = (x + m / 2) & ~(m - 1);
		if (x > 32'sh1FFFFF) x = 32'sh1FFFFF & ~(m - 1);
		return x;
	endfunction : fmodel
	function automatic logic [15:0] hi(int x);
		logic [31:0] y;
		y = x;
		return y[21:6] ^ {off, 15'h0000};
	endfunction : hi
	function automatic int tree(logic [7:0] s, int m[4], bit second);
		int bs;
		bs = (s[5] ? m[3] : 0) + (s[6] ? m[1] : 0) + (s[7] ? m[2] : 0);
		if (second) return bs;
		return (s[0] ? (s[1] ? m[0] : 0) + (s[2] ? m[1] : 0) + (s[3] ? m[2] : 0) : 0)
			+ (s[4] ? bs : 0);
	endfunction : tree
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#(40 * 3000);
		errors++;
		wrap_up();
	end
	initial begin
		v = $urandom(32'h2AC5);
		{rst_n, cas_i, ilv, ilv2, quiet, off, fmt, rnd, rnd2, shift} = '0;
		{mix_i, mix_q, cas_word, sel_i, sel_q, src2, src3, src4} = '0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("reset port one", o1, 16'h0000);
		rst_n = 1'b1;
		// ----------------------------------------
		// Cascade stream, one setting per block
		// ----------------------------------------
		for (int b = 0; b < 5; b++) begin
			fmt = (b == 0) ? 2'h3 : 2'(b - 1);
			shift = (b == 0) ? 3'h0 : 3'($urandom_range(7));
			rnd = (b == 0) ? 2'h0 : 2'($urandom);
			off = (b == 0) ? 1'b0 : 1'($urandom);
			src2 = (b == 0) ? P2_LOW : codes2[$urandom_range(2)];
			src4 = $urandom_range(1) ? P4_INV : P4_ZERO;
			ilv = (fmt == 2'h1);
			wq.delete();
			iq.delete();
			for (int n = 0; n < 40; n++) begin
				if (wq.size() == 14) begin
					xv = fmodel(wq.pop_front(), shift, rnd);
					e1 = hi(xv);
					e2 = (src2 == P2_LOW) ? {xv[5:0], 10'h000} : (src2 == P2_INV) ? ~e1 : 16'h0000;
					chk("port one", o1, e1);
					chk("port two", o2, e2);
					chk("port three", o3, 16'h0000);
					chk("port four", o4, src4 == P4_INV ? 16'hFFFF : 16'h0000);
					chk("enable", oe3, fmt == 2'h0);
					chk("enable four", oe4, fmt == 2'h0);
					chk("phase flag", flag, iq.pop_front());
				end
				cas_word = 22'($urandom);
				v = $signed(cas_word);
				v = v >>> $urandom_range(16);
				cas_word = 22'(v);
				cas_i = !n[0];
				v = (fmt == 2'h0) ? 0 : (fmt == 2'h2) ? $signed({cas_word[21:6], 6'h00}) : v;
				wq.push_back(v);
				iq.push_back(cas_i);
				@(negedge clk_sys);
			end
		end
		// ----------------------------------------
		// Mixer sums with cascade off
		// ----------------------------------------
		{fmt, ilv, rnd, off, cas_i} = '0;
		shift = 3'($urandom_range(7));
		for (int t = 0; t < 4; t++) begin
			sel_i = sels[t];
			sel_q = sels[(t + 1) % 4];
			// Odd passes steer the other decoded sources onto the same ports
			{src2, src3, src4} = t[0] ? {P2_QA, P3_IB, P4_QA_LOW} : {P2_IB, P3_QA, P4_QB};
			for (int k = 0; k < 4; k++) begin
				ma[k] = $urandom_range(32767) - 16384;
				mq[k] = $urandom_range(32767) - 16384;
				mix_i[k] = 21'(ma[k]);
				mix_q[k] = 21'(mq[k]);
			end
			repeat (8) @(negedge clk_sys);
			xv = fmodel(tree(sel_q, mq, 0), shift, 0);
			e1 = hi(fmodel(tree(sel_i, ma, 1), shift, 0));
			e2 = t[0] ? {xv[5:0], 10'h000} : hi(fmodel(tree(sel_q, mq, 1), shift, 0));
			chk("first i", o1, hi(fmodel(tree(sel_i, ma, 0), shift, 0)));
			chk("second i", t[0] ? o3 : o2, e1);
			chk("first q", t[0] ? o2 : o3, hi(xv));
			chk("port four", o4, e2);
		end
		// Third and fourth paths alone: one-bit upshift, no shifter, at most 16 bits
		{src3, src4} = {P3_IC, P4_ID};
		rnd2 = 2'($urandom);
		repeat (8) @(negedge clk_sys);
		v = (rnd2 == 2'h0) ? 1 : rnd2;
		chk("third path", o3, hi(fmodel(ma[2] * 2, 0, v)));
		chk("fourth path", o4, hi(fmodel(ma[3] * 2, 0, v)));
		{quiet, rnd2, src3, src4} = {1'b1, 2'h0, P3_IC, P4_ID};
		repeat (20) @(negedge clk_sys);
		chk("quiet three", o3, 16'h7FFF);
		chk("quiet four", o4, 16'h7FFF);
		wrap_up();
	end
endmodule : tsf_formatter_test
`default_nettype wire
